/* design/system_clock_power_mode_control.sv */
// system clock source, divider, power modes and clock output pin
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module system_clock_power_mode_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic main_oscillator_input,
   input wire logic sub_oscillator_input,
   input wire logic wait_instruction,
   input wire logic wake_interrupt,
   output logic system_clock_enable,
   output logic peripheral_clock_enable,
   output logic sub_peripheral_clock_enable,
   output logic watchdog_clock_enable,
   output logic converter_clock_enable,
   output logic main_oscillator_enable,
   output logic sub_oscillator_enable,
   output logic main_peripheral_clock_div1,
   output logic main_peripheral_clock_div32,
   output logic sub_peripheral_clock_div1,
   output logic clock_output_pin,
   output logic port_hold,
   output logic interrupt_service_request
);
   typedef struct packed {
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [7:0] protect;
      logic [7:0] ratio;
      logic start;
      logic [7:0] count;
      logic div_out;
      logic [4:0] pre32;
      logic [7:0] bclk_cnt;
      logic bclk_en;
      clk_pwr_pkg::power_mode_t mode;
      logic pin;
      logic isr_req;
      logic [31:0] rdata;
      logic [2:0] main_sync;
      logic [2:0] sub_sync;
      logic main_lvl;
      logic sub_lvl;
   } state_t;

   state_t s, next_s;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      hit = (a == b);
   endfunction

   logic access, wr, rd_ok, low_speed, sub_sel, div_tick, underflow, div8_on;
   logic main_rise, sub_rise;
   logic [1:0] out_sel;
   logic [7:0] bclk_last;

   always_comb begin
      access = psel && penable;
      wr = access && pwrite && pstrb[0];
      sub_sel = s.ctrl0[clk_pwr_pkg::ctrl0_sub_sel] && s.ctrl0[clk_pwr_pkg::ctrl0_sub_osc_en];
      low_speed = s.ctrl0[clk_pwr_pkg::ctrl0_sub_sel];
      out_sel = s.ctrl0[clk_pwr_pkg::ctrl0_clkout_sel_lo +: 2];
      div8_on = s.ctrl0[clk_pwr_pkg::ctrl0_div8];
      rd_ok = hit(paddr, clk_pwr_pkg::addr_ctrl0) || hit(paddr, clk_pwr_pkg::addr_ctrl1)
         || hit(paddr, clk_pwr_pkg::addr_protect) || hit(paddr, clk_pwr_pkg::addr_clkout)
         || hit(paddr, clk_pwr_pkg::addr_status);
      // one-cycle marks of an accepted rising edge of each oscillator
      main_rise = !s.main_lvl && s.main_sync[2] && s.main_sync[1];
      sub_rise = !s.sub_lvl && s.sub_sync[2] && s.sub_sync[1];
      if (div8_on) begin
         bclk_last = clk_pwr_pkg::bclk_div8_last;
      end else begin
         case (s.ctrl1[clk_pwr_pkg::ctrl1_div_hi -: 2])
            2'b00: bclk_last = clk_pwr_pkg::bclk_div1_last;
            2'b01: bclk_last = clk_pwr_pkg::bclk_div2_last;
            2'b10: bclk_last = clk_pwr_pkg::bclk_div4_last;
            default: bclk_last = clk_pwr_pkg::bclk_div16_last;
         endcase
      end
      div_tick = (s.pre32 == clk_pwr_pkg::div32_last) && main_rise;
      underflow = s.start && div_tick && (s.count == 8'h00);
   end

   always_comb begin
      next_s = s;
      next_s.main_sync = {s.main_sync[1:0], main_oscillator_input};
      next_s.sub_sync = {s.sub_sync[1:0], sub_oscillator_input};
      if (s.main_sync[2] == s.main_sync[1]) begin
         next_s.main_lvl = s.main_sync[2];
      end
      if (s.sub_sync[2] == s.sub_sync[1]) begin
         next_s.sub_lvl = s.sub_sync[2];
      end
      next_s.isr_req = 1'b0;
      // register writes
      if (wr) begin
         if (hit(paddr, clk_pwr_pkg::addr_protect)) begin
            next_s.protect = pwdata[7:0];
         end
         if (s.protect[clk_pwr_pkg::protect_we]) begin
            if (hit(paddr, clk_pwr_pkg::addr_ctrl0)) begin
               next_s.ctrl0 = pwdata[7:0];
            end
            if (hit(paddr, clk_pwr_pkg::addr_ctrl1)) begin
               next_s.ctrl1 = pwdata[7:0] & clk_pwr_pkg::ctrl1_wmask;
            end
         end
         if (hit(paddr, clk_pwr_pkg::addr_clkout)) begin
            next_s.ratio = pwdata[7:0];
            next_s.start = pwdata[clk_pwr_pkg::clkout_start];
         end
      end
      // power mode sequencing
      case (s.mode)
         clk_pwr_pkg::pm_run: begin
            if (s.ctrl1[clk_pwr_pkg::ctrl1_all_stop]) begin
               next_s.mode = clk_pwr_pkg::pm_stop;
               if (!low_speed) begin
                  next_s.ctrl0[clk_pwr_pkg::ctrl0_div8] = 1'b1;
               end
            end else if (wait_instruction) begin
               next_s.mode = clk_pwr_pkg::pm_wait;
            end
         end
         clk_pwr_pkg::pm_wait: begin
            if (wake_interrupt) begin
               next_s.mode = clk_pwr_pkg::pm_run;
               next_s.isr_req = 1'b1;
            end
         end
         clk_pwr_pkg::pm_stop: begin
            if (wake_interrupt) begin
               next_s.mode = clk_pwr_pkg::pm_run;
               next_s.isr_req = 1'b1;
               next_s.ctrl1[clk_pwr_pkg::ctrl1_all_stop] = 1'b0;
            end
         end
         default: next_s.mode = clk_pwr_pkg::pm_run;
      endcase
      // divider clocks run except in stop or with the main oscillator stopped; peripheral gating in wait
      if (s.mode != clk_pwr_pkg::pm_stop
         && !(s.mode == clk_pwr_pkg::pm_wait && s.ctrl0[clk_pwr_pkg::ctrl0_wait_pclk_stop])
         && !s.ctrl0[clk_pwr_pkg::ctrl0_main_stop]) begin
         if (main_rise) begin
            next_s.pre32 = 5'(s.pre32 + 5'h01);
         end
         if (s.start && div_tick) begin
            if (s.count == 8'h00) begin
               next_s.count = s.ratio;
               next_s.div_out = ~s.div_out;
            end else begin
               next_s.count = 8'(s.count - 8'h01);
            end
         end
      end
      if (!s.start) begin
         next_s.count = s.ratio;
      end
      // system clock enable pulse from divider, or from sub oscillator edges when sub clock is selected
      next_s.bclk_en = 1'b0;
      if (s.mode == clk_pwr_pkg::pm_run) begin
         if (sub_sel) begin
            next_s.bclk_en = sub_rise;
         end else if (main_rise) begin
            if (s.bclk_cnt >= bclk_last) begin
               next_s.bclk_cnt = 8'h00;
               next_s.bclk_en = 1'b1;
            end else begin
               next_s.bclk_cnt = 8'(s.bclk_cnt + 8'h01);
            end
         end
      end
      // clock output pin
      case (s.mode)
         clk_pwr_pkg::pm_stop: begin
            if (out_sel == clk_pwr_pkg::clkout_sub) begin
               next_s.pin = 1'b1;
            end
         end
         clk_pwr_pkg::pm_wait: begin
            if (out_sel == clk_pwr_pkg::clkout_sub) begin
               next_s.pin = s.sub_lvl;
            end else if (!s.ctrl0[clk_pwr_pkg::ctrl0_wait_pclk_stop]) begin
               next_s.pin = (out_sel == clk_pwr_pkg::clkout_main) ? s.main_lvl : s.div_out;
            end
         end
         default: begin
            case (out_sel)
               clk_pwr_pkg::clkout_main: next_s.pin = s.main_lvl;
               clk_pwr_pkg::clkout_sub: next_s.pin = s.sub_lvl;
               clk_pwr_pkg::clkout_divider: next_s.pin = s.div_out;
               default: next_s.pin = 1'b0;
            endcase
         end
      endcase
      // read data
      next_s.rdata = 32'h00000000;
      if (psel && !penable && !pwrite) begin
         if (hit(paddr, clk_pwr_pkg::addr_ctrl0)) begin
            next_s.rdata = {24'h000000, s.ctrl0};
         end else if (hit(paddr, clk_pwr_pkg::addr_ctrl1)) begin
            next_s.rdata = {24'h000000, s.ctrl1};
         end else if (hit(paddr, clk_pwr_pkg::addr_protect)) begin
            next_s.rdata = {24'h000000, s.protect};
         end else if (hit(paddr, clk_pwr_pkg::addr_clkout)) begin
            next_s.rdata = {23'h000000, s.start, s.ratio};
         end else if (hit(paddr, clk_pwr_pkg::addr_status)) begin
            next_s.rdata = {20'h00000, s.count, s.div_out, 1'b0, s.mode};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.ctrl0 <= clk_pwr_pkg::ctrl0_reset;
         s.ctrl1 <= clk_pwr_pkg::ctrl1_reset;
         s.mode <= clk_pwr_pkg::pm_run;
      end else begin
         s <= next_s;
      end
   end

   assign pready = 1'b1;
   assign pslverr = access && !rd_ok;
   assign prdata = s.rdata;
   assign system_clock_enable = s.bclk_en;
   assign peripheral_clock_enable = !s.ctrl0[clk_pwr_pkg::ctrl0_main_stop]
      && ((s.mode == clk_pwr_pkg::pm_run)
      || (s.mode == clk_pwr_pkg::pm_wait && !s.ctrl0[clk_pwr_pkg::ctrl0_wait_pclk_stop]));
   assign sub_peripheral_clock_enable = (s.mode != clk_pwr_pkg::pm_stop);
   assign watchdog_clock_enable = (s.mode == clk_pwr_pkg::pm_run);
   assign converter_clock_enable = peripheral_clock_enable && !s.ctrl0[clk_pwr_pkg::ctrl0_main_stop];
   assign main_oscillator_enable = (s.mode != clk_pwr_pkg::pm_stop)
      && !s.ctrl0[clk_pwr_pkg::ctrl0_main_stop];
   assign sub_oscillator_enable = (s.mode != clk_pwr_pkg::pm_stop)
      && s.ctrl0[clk_pwr_pkg::ctrl0_sub_osc_en];
   assign main_peripheral_clock_div1 = s.main_lvl && peripheral_clock_enable;
   assign main_peripheral_clock_div32 = div_tick && peripheral_clock_enable;
   assign sub_peripheral_clock_div1 = s.sub_lvl && sub_peripheral_clock_enable;
   assign clock_output_pin = s.pin;
   assign port_hold = (s.mode != clk_pwr_pkg::pm_run);
   assign interrupt_service_request = s.isr_req;
   logic unused;
   assign unused = underflow ^ (|pwdata[31:9]) ^ (|pstrb[3:1]);
endmodule // system_clock_power_mode_control

/* design/clk_pwr_pkg.sv */
// constants and register map for the clock and power mode controller
package clk_pwr_pkg;
   // register byte addresses (registers sit at word offsets on the bus)
   localparam int idx_ctrl0 = 6;
   localparam int idx_ctrl1 = 7;
   localparam int idx_protect = 10;
   localparam logic [11:0] addr_ctrl0 = 12'(idx_ctrl0 * 4);
   localparam logic [11:0] addr_ctrl1 = 12'(idx_ctrl1 * 4);
   localparam logic [11:0] addr_protect = 12'(idx_protect * 4);
   localparam logic [11:0] addr_clkout = 12'h100;
   localparam logic [11:0] addr_status = 12'h104;
   // control register 0 fields
   localparam int ctrl0_clkout_sel_lo = 0;
   localparam int ctrl0_wait_pclk_stop = 2;
   localparam int ctrl0_sub_osc_en = 4;
   localparam int ctrl0_main_stop = 5;
   localparam int ctrl0_div8 = 6;
   localparam int ctrl0_sub_sel = 7;
   // control register 1 fields
   localparam int ctrl1_all_stop = 0;
   localparam int ctrl1_div_lo = 6;
   localparam int ctrl1_div_hi = 7;
   localparam int protect_we = 0;
   localparam int clkout_start = 8;
   localparam logic [7:0] ctrl0_reset = 8'h48;
   localparam logic [7:0] ctrl1_reset = 8'h20;
   localparam logic [7:0] ctrl1_wmask = 8'he1;
   // clock output source select
   localparam logic [1:0] clkout_main = 2'h1;
   localparam logic [1:0] clkout_sub = 2'h2;
   localparam logic [1:0] clkout_divider = 2'h3;
   localparam logic [4:0] div32_last = 5'h1f;
   localparam logic [7:0] bclk_div1_last = 8'h00;
   localparam logic [7:0] bclk_div2_last = 8'h01;
   localparam logic [7:0] bclk_div4_last = 8'h03;
   localparam logic [7:0] bclk_div8_last = 8'h07;
   localparam logic [7:0] bclk_div16_last = 8'h0f;
   typedef enum logic [1:0] {
      pm_run,
      pm_wait,
      pm_stop
   } power_mode_t;
endpackage

/* dv/clk_pwr_props.sv */
// assertions on the clock and power mode controller ports
`timescale 1ns/1ps
module clk_pwr_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wake_interrupt,
   input wire logic system_clock_enable,
   input wire logic watchdog_clock_enable,
   input wire logic converter_clock_enable,
   input wire logic main_oscillator_enable,
   input wire logic sub_oscillator_enable,
   input wire logic main_peripheral_clock_div1,
   input wire logic main_peripheral_clock_div32,
   input wire logic port_hold,
   input wire logic interrupt_service_request
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_wdog; port_hold |-> !watchdog_clock_enable; endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog runs in hold");
   property p_sysclk; port_hold [*3] |-> !system_clock_enable; endproperty
   a_sysclk: assert property (p_sysclk) else $error("bus clock runs in hold");
   property p_stop;
      !main_oscillator_enable && !sub_oscillator_enable |-> port_hold && !converter_clock_enable;
   endproperty
   a_stop: assert property (p_stop) else $error("stop state inconsistent");
   property p_isr; $rose(interrupt_service_request) |-> $past(port_hold) || $past(port_hold, 2);
   endproperty
   a_isr: assert property (p_isr) else $error("service request without hold");
   property p_isr_one; interrupt_service_request |=> !interrupt_service_request; endproperty
   a_isr_one: assert property (p_isr_one) else $error("service request too long");
   property p_wake; port_hold && wake_interrupt |-> ##[1:8] !port_hold; endproperty
   a_wake: assert property (p_wake) else $error("no wake from hold");
   property p_lowpwr;
      !main_oscillator_enable && sub_oscillator_enable |-> !main_peripheral_clock_div1;
   endproperty
   a_lowpwr: assert property (p_lowpwr) else $error("main clock in low power");
   property p_div32;
      main_peripheral_clock_div32 |=> !main_peripheral_clock_div32 [*8];
   endproperty
   a_div32: assert property (p_div32) else $error("div32 pulses too close");
   c_wake: cover property ($fell(port_hold));
   c_isr: cover property (interrupt_service_request);
   c_lowpwr: cover property (!main_oscillator_enable && sub_oscillator_enable);
endmodule // clk_pwr_props
bind system_clock_power_mode_control clk_pwr_props u_props (.pclk, .presetn, .wake_interrupt,
   .system_clock_enable, .watchdog_clock_enable, .converter_clock_enable,
   .main_oscillator_enable, .sub_oscillator_enable, .main_peripheral_clock_div1,
   .main_peripheral_clock_div32, .port_hold, .interrupt_service_request);

/* dv/cpu_model.sv */
// cpu core and interrupt logic model driving wait and wake requests
`timescale 1ns/1ps
module cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go_wait,
   input wire logic go_wake,
   input wire logic [3:0] lag,
   input wire logic port_hold,
   output logic wait_instruction,
   output logic wake_interrupt
);
   logic [3:0] cnt;
   logic pend;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_instruction <= 1'b0;
         wake_interrupt <= 1'b0;
         cnt <= 4'h0;
         pend <= 1'b0;
      end else begin
         wait_instruction <= go_wait;
         if (go_wake) begin
            pend <= 1'b1;
            cnt <= lag;
         end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (pend) begin
            wake_interrupt <= port_hold;
            pend <= port_hold;
         end
      end
   end
endmodule // cpu_model

/* dv/tb_top.sv */
// self-checking bench for the clock and power mode controller
`timescale 1ns/1ps
module tb_top;
   localparam logic [11:0] a0 = clk_pwr_pkg::addr_ctrl0;
   localparam logic [11:0] a1 = clk_pwr_pkg::addr_ctrl1;
   localparam logic [11:0] ap = clk_pwr_pkg::addr_protect;
   localparam logic [11:0] ak = clk_pwr_pkg::addr_clkout;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, seed;
   logic [3:0] osc = 4'h0, lag = 4'h0;
   logic [1:0] mosc = 2'h0;
   logic go_wait = 1'b0, go_wake = 1'b0, pready, pslverr, wait_instruction, wake_interrupt;
   logic system_clock_enable, peripheral_clock_enable, sub_peripheral_clock_enable;
   logic watchdog_clock_enable, converter_clock_enable, main_oscillator_enable;
   logic sub_oscillator_enable, main_peripheral_clock_div1, main_peripheral_clock_div32;
   logic sub_peripheral_clock_div1, clock_output_pin, port_hold, interrupt_service_request;
   logic [32:0] rd_q[$], gap_q[$], tick_q[$];
   logic [7:0] r;
   logic p, armed = 1'b0, parmed = 1'b0, pin_last = 1'b0;
   int err_total = 0, total_checks = 0, gap = 0, ticks = 0, ndiv[4] = '{1, 2, 4, 16};
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (main_oscillator_enable === 1'b1)
         mosc <= mosc + 2'h1;
      if (sub_oscillator_enable === 1'b1)
         osc <= osc + 4'h1;
   end
   system_clock_power_mode_control u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .main_oscillator_input(mosc[1]),
      .sub_oscillator_input(osc[3]), .wait_instruction, .wake_interrupt, .system_clock_enable,
      .peripheral_clock_enable, .sub_peripheral_clock_enable, .watchdog_clock_enable,
      .converter_clock_enable, .main_oscillator_enable, .sub_oscillator_enable,
      .main_peripheral_clock_div1, .main_peripheral_clock_div32, .sub_peripheral_clock_div1,
      .clock_output_pin, .port_hold, .interrupt_service_request);
   cpu_model u_cpu (.pclk, .presetn, .go_wait, .go_wake, .lag, .port_hold, .wait_instruction,
      .wake_interrupt);
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic guard(inout int n);
      n++;
      if (n > 3000) begin
         err_total++;
         stop_test();
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n = 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         guard(n);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(a, 1'b0, 32'h0);
   endtask
   task automatic drain;
      int n = 0;
      while (gap_q.size() + tick_q.size() > 0) begin
         @(posedge pclk);
         guard(n);
      end
   endtask
   task automatic hold_is(input logic v);
      int n = 0;
      while (port_hold !== v && n < 3000) begin
         @(posedge pclk);
         guard(n);
      end
      chk(33'(port_hold), 33'(v));
   endtask
   task automatic wake;
      lag <= 4'($random(seed));
      go_wake <= 1'b1;
      @(posedge pclk);
      go_wake <= 1'b0;
      hold_is(1'b0);
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
         chk({pslverr, prdata}, rd_q.pop_front());
      gap <= gap + 1;
      if (system_clock_enable === 1'b1) begin
         gap <= 1;
         if (armed && gap_q.size() > 0)
            chk(33'(gap), gap_q.pop_front());
         armed <= gap_q.size() > 0;
      end
      if (main_peripheral_clock_div32 === 1'b1)
         ticks <= ticks + 1;
      if (clock_output_pin !== pin_last) begin
         pin_last <= clock_output_pin;
         ticks <= 0;
         if (parmed && tick_q.size() > 0)
            chk(33'(ticks), tick_q.pop_front());
         parmed <= tick_q.size() > 0;
      end
   end
   initial begin
      seed = 32'hadf2878b;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(a0, 33'h48);
      rd(a1, 33'h20);
      rd(ap, 33'h0);
      rd(12'h0ff, 33'h100000000);
      gap_q.push_back(33'h20);
      drain();
      apb(a1, 1'b1, 32'hc0);
      rd(a1, 33'h20);
      apb(ap, 1'b1, 32'h1);
      apb(a0, 1'b1, 32'h0);
      for (int k = 0; k < 4; k++) begin
         apb(a1, 1'b1, {24'h0, k[1:0], 6'h0});
         repeat (80) @(posedge pclk);
         gap_q.push_back(33'(4 * ndiv[k]));
         drain();
      end
      $display("divider test done");
      r = $random(seed);
      apb(a0, 1'b1, 32'h3);
      apb(ak, 1'b1, {23'h0, 1'b1, 6'h0, r[1:0]});
      tick_q.push_back(33'(r[1:0]) + 33'h1);
      tick_q.push_back(33'(r[1:0]) + 33'h1);
      drain();
      apb(ak, 1'b1, 32'h0);
      repeat (20) @(posedge pclk);
      p = clock_output_pin;
      repeat (600) @(posedge pclk);
      chk(33'(clock_output_pin), 33'(p));
      $display("clock output test done");
      apb(a0, 1'b1, 32'h2);
      apb(a1, 1'b1, 32'hc1);
      hold_is(1'b1);
      @(posedge pclk);
      chk(33'({clock_output_pin, main_oscillator_enable, sub_oscillator_enable,
         converter_clock_enable, sub_peripheral_clock_div1, main_peripheral_clock_div1}),
         33'h20);
      rd(a0, 33'h42);
      wake();
      rd(a1, 33'hc0);
      apb(a0, 1'b1, 32'h6);
      go_wait <= 1'b1;
      @(posedge pclk);
      go_wait <= 1'b0;
      hold_is(1'b1);
      chk(33'({peripheral_clock_enable, sub_peripheral_clock_enable}), 33'h1);
      wake();
      gap_q.push_back(33'h40);
      drain();
      apb(a0, 1'b1, 32'h10);
      repeat (200) @(posedge pclk);
      apb(a0, 1'b1, 32'h90);
      apb(a0, 1'b1, 32'hb0);
      chk(33'({main_oscillator_enable, sub_oscillator_enable}), 33'h1);
      gap_q.push_back(33'h10);
      drain();
      apb(ap, 1'b1, 32'h0);
      apb(a0, 1'b1, 32'h0);
      rd(a0, 33'hb0);
      $display("power mode test done");
      stop_test();
   end
endmodule // tb_top
